// File: pkg/stf_defs.svh
// Register map, field positions and constants of the framer
`ifndef STF_DEFS_SVH
`define STF_DEFS_SVH
`define STF_OFF_CMD 8'h00
`define STF_OFF_RXCTL 8'h04
`define STF_OFF_MODE 8'h08
`define STF_OFF_TXCTL 8'h0c
`define STF_OFF_INTCTL 8'h10
`define STF_OFF_DATA 8'h14
`define STF_OFF_STAT 8'h18
`define STF_CMD_ABORT 3'h1
`define STF_CMD_RST_EXT 3'h2
`define STF_CMD_RST_TXP 3'h5
`define STF_CMD_RST_CRC 3'h6
`define STF_CMD_RST_EOM 3'h7
`define STF_TXC_DTR 7
`define STF_TXC_EN 3
`define STF_TXC_RTS 1
`define STF_TXC_CRCEN 0
`define STF_MODE_BITFRAME 5
`define STF_RXC_MASK 8'hfd
`define STF_TXC_MASK 8'heb
`define STF_IC_TXIE 0
`define STF_IC_EXTIE 1
`define STF_IC_WREN 2
`define STF_IC_RDYFN 3
`define STF_FLAG_WORD 16'h007e
`define STF_ABORT_WORD 16'h00ff
`define STF_MARK_WORD 16'hffff
`define STF_CRC_POLY 16'h8408
`define STF_CRC_PRESET 16'hffff
`define STF_STUFF_RUN 3'h5
`define STF_LEN_FLAG 5'h08
`define STF_LEN_CRC 5'h10
`define STF_LEN_MARK 5'h01
`define STF_CRC_MIN_TICKS 5'h10
`endif

// File: pkg/stf_pkg.sv
// Types shared by the framer files
package stf_pkg;
  typedef enum logic [4:0]
  {
    ST_MARK = 5'b00001,
    ST_FLAG = 5'b00010,
    ST_DATA = 5'b00100,
    ST_CRC = 5'b01000,
    ST_ABORT = 5'b10000
  } stf_state_e;
  typedef logic [4:0] stf_len_t;
endpackage

// File: hw/stf_sync3.sv
// Three-stage pin synchroniser with falling edge pulse
`timescale 1ns/1ps
module stf_sync3
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic fall_q
);
  logic s1_q, s2_q, s3_q, lvl_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Level moves only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvl_q <= 1'b1;
      fall_q <= 1'b0;
    end
    else
    begin
      if (s2_q == s3_q)
      begin
        lvl_q <= s2_q;
      end
      fall_q <= (s2_q == s3_q) && lvl_q && !s2_q;
    end
  end
endmodule

// File: hw/stf_crc16.sv
// Serial frame check generator, lsb first
`timescale 1ns/1ps
`include "stf_defs.svh"
module stf_crc16
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic init,
  input wire logic en,
  input wire logic din,
  output logic [15:0] crc_q
);
  logic fb;
  assign fb = crc_q[0] ^ din;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      crc_q <= `STF_CRC_PRESET;
    end
    else if (init)
    begin
      crc_q <= `STF_CRC_PRESET;
    end
    else if (en)
    begin
      crc_q <= (crc_q >> 1) ^ (fb ? `STF_CRC_POLY : 16'h0000);
    end
  end
endmodule

// File: hw/stf_tx_framer.sv
// Bit-oriented transmit framer with APB register access
`timescale 1ns/1ps
`include "stf_defs.svh"
module stf_tx_framer
  import stf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  input wire logic txc,
  output logic txd_q,
  output logic int_n_q,
  output logic wait_n_q,
  output logic ready_n_q,
  output logic dtr_n_q,
  output logic rts_n_q
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0] rxctl_q, mode_q, txctl_q, intctl_q, buf_q;
  logic buf_full_q, eom_q, txp_q, extp_q, abort_req_q;
  stf_state_e st_q, n_st;
  logic [15:0] sh_q, n_word;
  stf_len_t bits_q, n_len;
  logic [2:0] ones_q;
  logic tick, tx_en, stuff, load, sw_abort, emit_data;
  logic [15:0] crc;
  logic crc_init, crc_en, bit_out;
  logic wr_go, wr_data, cmd_go, blocked, mapped;
  logic [2:0] cmd;
  logic ld_data, ld_crc, ld_flag_after_crc;

  function automatic stf_len_t len_of(input logic [1:0] code);
    case (code)
      2'b00: len_of = 5'h05;
      2'b10: len_of = 5'h06;
      2'b01: len_of = 5'h07;
      2'b11: len_of = 5'h08;
      default: len_of = 5'h08;
    endcase
  endfunction

  function automatic logic is_off(input logic [7:0] a, input logic [7:0] off);
    is_off = (a == off);
  endfunction

  stf_sync3 u_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .pin(txc),
    .fall_q(tick)
  );

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign wr_go = psel && penable && pready_q && pwrite && !pslverr_q;
  assign wr_data = wr_go && is_off(paddr, `STF_OFF_DATA);
  assign cmd_go = wr_go && is_off(paddr, `STF_OFF_CMD);
  assign cmd = pwdata[2:0];
  assign mapped = paddr <= `STF_OFF_STAT && paddr[1:0] == 2'b00;
  assign blocked = intctl_q[`STF_IC_WREN] && !intctl_q[`STF_IC_RDYFN] && pwrite
    && is_off(paddr, `STF_OFF_DATA) && buf_full_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else if (psel && penable && !pready_q && !blocked)
    begin
      pready_q <= 1'b1;
      pslverr_q <= !mapped;
      prdata_q <= 32'h00000000;
      if (!pwrite && is_off(paddr, `STF_OFF_INTCTL))
      begin
        prdata_q <= {24'h000000, intctl_q};
      end
      else if (!pwrite && is_off(paddr, `STF_OFF_STAT))
      begin
        // empty flag hidden while CRC shifts
        prdata_q <= {26'h0000000, st_q == ST_ABORT, st_q == ST_CRC, extp_q, txp_q, eom_q,
          !buf_full_q && st_q != ST_CRC};
      end
    end
    else
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxctl_q <= 8'h00;
      mode_q <= 8'h00;
      txctl_q <= 8'h00;
      intctl_q <= 8'h00;
    end
    else if (wr_go)
    begin
      // receive control fields, bit 1 zero
      if (is_off(paddr, `STF_OFF_RXCTL))
      begin
        rxctl_q <= pwdata[7:0] & `STF_RXC_MASK;
      end
      if (is_off(paddr, `STF_OFF_MODE))
      begin
        mode_q <= pwdata[7:0];
      end
      if (is_off(paddr, `STF_OFF_TXCTL))
      begin
        txctl_q <= pwdata[7:0] & `STF_TXC_MASK;
      end
      if (is_off(paddr, `STF_OFF_INTCTL))
      begin
        intctl_q <= pwdata[7:0];
      end
    end
  end

  // framing only with bit framing mode selected
  assign tx_en = txctl_q[`STF_TXC_EN] && mode_q[`STF_MODE_BITFRAME];
  assign sw_abort = cmd_go && cmd == `STF_CMD_ABORT;

  // ----------------------------------------
  // Next character selection
  // ----------------------------------------
  // zero after five ones in data and CRC
  assign stuff = ones_q == `STF_STUFF_RUN && (st_q == ST_DATA || st_q == ST_CRC) && !abort_req_q;
  assign load = bits_q == 5'h00 && !stuff;

  always_comb
  begin
    n_st = st_q;
    n_word = `STF_MARK_WORD;
    n_len = `STF_LEN_MARK;
    if (abort_req_q)
    begin
      n_st = ST_ABORT;
      n_word = `STF_ABORT_WORD;
      n_len = `STF_LEN_FLAG;
    end
    else if (!load)
    begin
      n_st = st_q;
    end
    else if (!tx_en)
    begin
      n_st = ST_MARK;
    end
    else if (buf_full_q)
    begin
      n_st = ST_DATA;
      n_word = {8'h00, buf_q};
      n_len = len_of(txctl_q[6:5]);
    end
    else if (st_q == ST_DATA && !eom_q)
    begin
      n_st = ST_CRC;
      n_word = ~crc;
      n_len = `STF_LEN_CRC;
    end
    else
    begin
      // flags when flag set or idle
      n_st = ST_FLAG;
      n_word = `STF_FLAG_WORD;
      n_len = `STF_LEN_FLAG;
    end
  end

  assign ld_data = tick && load && !abort_req_q && tx_en && buf_full_q;
  // underrun: shifter done with buffer empty
  assign ld_crc = tick && !abort_req_q && load && n_st == ST_CRC && st_q == ST_DATA;
  assign ld_flag_after_crc = tick && !abort_req_q && load && n_st == ST_FLAG && st_q == ST_CRC;
  assign bit_out = (abort_req_q || load) ? n_word[0] : (stuff ? 1'b0 : sh_q[0]);
  assign emit_data = (abort_req_q || load) ? n_st == ST_DATA : (st_q == ST_DATA && !stuff);

  // ----------------------------------------
  // Shifter and line output
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= ST_MARK;
      sh_q <= `STF_MARK_WORD;
      bits_q <= 5'h00;
      txd_q <= 1'b1;
    end
    else if (tick)
    begin
      txd_q <= bit_out;
      if (abort_req_q || load)
      begin
        st_q <= n_st;
        sh_q <= n_word >> 1;
        bits_q <= n_len - 5'h01;
      end
      else if (!stuff)
      begin
        sh_q <= sh_q >> 1;
        bits_q <= bits_q - 5'h01;
      end
    end
  end

  // Run of ones counted only in stuffed states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ones_q <= 3'h0;
    end
    else if (tick)
    begin
      if (!(emit_data || ((abort_req_q || load) ? n_st == ST_CRC : st_q == ST_CRC)) || !bit_out)
      begin
        ones_q <= 3'h0;
      end
      else
      begin
        ones_q <= ones_q + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // Frame check
  // ----------------------------------------
  // preset at each flag or abort
  assign crc_init = (tick && (abort_req_q || load) && (n_st == ST_FLAG || n_st == ST_ABORT))
    || (cmd_go && cmd == `STF_CMD_RST_CRC);
  assign crc_en = tick && emit_data && txctl_q[`STF_TXC_CRCEN];

  stf_crc16 u_crc
  (
    .pclk(pclk),
    .presetn(presetn),
    .init(crc_init),
    .en(crc_en),
    .din(bit_out),
    .crc_q(crc)
  );

  // ----------------------------------------
  // Buffer, flags and commands
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buf_q <= 8'h00;
      buf_full_q <= 1'b0;
      abort_req_q <= 1'b0;
    end
    else
    begin
      if (wr_data)
      begin
        buf_q <= pwdata[7:0];
      end
      if (sw_abort)
      begin
        buf_full_q <= 1'b0;
      end
      else if (wr_data)
      begin
        buf_full_q <= 1'b1;
      end
      else if (ld_data)
      begin
        buf_full_q <= 1'b0;
      end
      if (sw_abort)
      begin
        abort_req_q <= 1'b1;
      end
      else if (tick)
      begin
        abort_req_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eom_q <= 1'b1;
      txp_q <= 1'b0;
      extp_q <= 1'b0;
    end
    else
    begin
      if (ld_crc)
      begin
        eom_q <= 1'b1;
      end
      else if (cmd_go && cmd == `STF_CMD_RST_EOM)
      begin
        eom_q <= 1'b0;
      end
      // set on buffer emptying, after CRC too
      if (intctl_q[`STF_IC_TXIE] && (ld_data || ld_flag_after_crc))
      begin
        txp_q <= 1'b1;
      end
      else if (wr_data || (cmd_go && cmd == `STF_CMD_RST_TXP))
      begin
        txp_q <= 1'b0;
      end
      if (intctl_q[`STF_IC_EXTIE] && ld_crc)
      begin
        extp_q <= 1'b1;
      end
      else if (cmd_go && cmd == `STF_CMD_RST_EXT)
      begin
        extp_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Registered pin outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_n_q <= 1'b1;
      wait_n_q <= 1'b1;
      ready_n_q <= 1'b1;
      dtr_n_q <= 1'b1;
      rts_n_q <= 1'b1;
    end
    else
    begin
      int_n_q <= !(txp_q || extp_q);
      // wait while buffer holds a character
      wait_n_q <= !(intctl_q[`STF_IC_WREN] && !intctl_q[`STF_IC_RDYFN] && buf_full_q);
      // ready while buffer can take one
      ready_n_q <= !(intctl_q[`STF_IC_WREN] && intctl_q[`STF_IC_RDYFN] && !buf_full_q && tx_en);
      dtr_n_q <= !txctl_q[`STF_TXC_DTR];
      rts_n_q <= !txctl_q[`STF_TXC_RTS];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // CRC length counter
  logic [4:0] crc_ticks_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      crc_ticks_q <= 5'h00;
    end
    else if (ld_crc)
    begin
      crc_ticks_q <= 5'h01;
    end
    else if (tick && st_q == ST_CRC && crc_ticks_q != 5'h1f)
    begin
      crc_ticks_q <= crc_ticks_q + 5'h01;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_crc_start;
    ld_crc;
  endsequence
  sequence s_crc_shown;
    eom_q && st_q == ST_CRC;
  endsequence
  property p_crc_eom;
    s_crc_start |=> s_crc_shown;
  endproperty
  a_crc_eom: assert property (p_crc_eom) else $error("CRC start without closed flag");
  property p_tbe_crc;
    pready_q && !pwrite && is_off(paddr, `STF_OFF_STAT) && $past(st_q == ST_CRC) |-> prdata_q[1:0] == 2'b10;
  endproperty
  a_tbe_crc: assert property (p_tbe_crc) else $error("Empty shown during CRC");
  property p_stuff;
    ones_q <= `STF_STUFF_RUN;
  endproperty
  a_stuff: assert property (p_stuff) else $error("Six ones in stuffed data");
  property p_abort_ones;
    st_q == ST_ABORT |-> txd_q;
  endproperty
  a_abort_ones: assert property (p_abort_ones) else $error("Zero sent during abort");
  property p_mark;
    st_q == ST_MARK |-> txd_q;
  endproperty
  a_mark: assert property (p_mark) else $error("Line not marking");
  property p_txp_cause;
    $rose(txp_q) |-> $past(tick) && $past(intctl_q[`STF_IC_TXIE]);
  endproperty
  a_txp_cause: assert property (p_txp_cause) else $error("Transmit interrupt without cause");
  property p_underrun;
    $rose(st_q == ST_CRC) |-> $past(!buf_full_q) && $past(!eom_q);
  endproperty
  a_underrun: assert property (p_underrun) else $error("CRC started without underrun");
  property p_ext;
    ld_crc && intctl_q[`STF_IC_EXTIE] |=> extp_q ##1 !int_n_q;
  endproperty
  a_ext: assert property (p_ext) else $error("Status interrupt missing");
  property p_crc_len;
    $fell(st_q == ST_CRC) && !$past(abort_req_q) |-> $past(crc_ticks_q) >= `STF_CRC_MIN_TICKS;
  endproperty
  a_crc_len: assert property (p_crc_len) else $error("CRC shorter than 16 bits");
  property p_wait;
    !wait_n_q |-> $past(buf_full_q);
  endproperty
  a_wait: assert property (p_wait) else $error("Wait without full buffer");
endmodule

// File: verification/stf_host_model.sv
// Host model: APB master and host-side register sequences
`timescale 1ns/1ps
`include "stf_defs.svh"
module stf_host_model
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata_q,
  input wire logic pready_q,
  input wire logic pslverr_q
);
  logic [31:0] rd_data;
  logic rd_err;
  int stall;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // ---------------------------------------------
  // Bus transfer, held until ready is sampled
  // ---------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {24'h0, data};
    @(posedge pclk);
    penable <= 1'b1;
    stall = 0;
    do
    begin
      @(posedge pclk);
      stall++;
    end
    while (pready_q !== 1'b1);
    rd_data = prdata_q;
    rd_err = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic open_link(input logic [7:0] txctl);
    xfer(1'b1, `STF_OFF_MODE, 8'h20);
    xfer(1'b1, `STF_OFF_TXCTL, txctl);
  endtask
  task automatic first_char(input logic [7:0] d);
    xfer(1'b1, `STF_OFF_CMD, 8'h06);
    xfer(1'b1, `STF_OFF_DATA, d);
    xfer(1'b1, `STF_OFF_CMD, 8'h07);
  endtask
endmodule

// File: verification/stf_tx_framer_bench.sv
// Self-checking bench of the transmit framer
`timescale 1ns/1ps
`include "stf_defs.svh"
module stf_tx_framer_bench;
  typedef struct {logic wr; logic [7:0] addr; logic [7:0] data; logic err; logic [7:0] rdata;
    logic dtr_n; logic rts_n;} stf_row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic txc = 1'b0;
  logic psel, penable, pwrite, pready_q, pslverr_q, txd_q, int_n_q;
  logic wait_n_q, ready_n_q, dtr_n_q, rts_n_q, v;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_q;
  int errors = 0;
  int samples_checked = 0;
  int run1, n, best;
  bit line_q[$];
  bit exp_q[$];
  stf_row_s rows[8] = '{'{1'b1, `STF_OFF_TXCTL, 8'h82, 1'b0, 8'h00, 1'b0, 1'b0},
    '{1'b1, `STF_OFF_TXCTL, 8'h80, 1'b0, 8'h00, 1'b0, 1'b1},
    '{1'b0, `STF_OFF_TXCTL, 8'h00, 1'b0, 8'h00, 1'b0, 1'b1},
    '{1'b1, `STF_OFF_RXCTL, 8'hff, 1'b0, 8'h00, 1'b0, 1'b1},
    '{1'b1, `STF_OFF_INTCTL, 8'h0f, 1'b0, 8'h00, 1'b0, 1'b1},
    '{1'b0, `STF_OFF_INTCTL, 8'h00, 1'b0, 8'h0f, 1'b0, 1'b1},
    '{1'b0, 8'h1c, 8'h00, 1'b1, 8'h00, 1'b0, 1'b1},
    '{1'b1, 8'h0e, 8'h02, 1'b1, 8'h00, 1'b0, 1'b1}};
  // ---------------------------------------------
  // Clocks, line capture and instances
  // ---------------------------------------------
  always #10 pclk = ~pclk;
  always #80 txc = ~txc;
  always @(negedge txc) line_q.push_back(txd_q);
  stf_host_model host
  (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q)
  );
  stf_tx_framer dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .txc(txc), .txd_q(txd_q), .int_n_q(int_n_q), .wait_n_q(wait_n_q),
    .ready_n_q(ready_n_q), .dtr_n_q(dtr_n_q), .rts_n_q(rts_n_q)
  );
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic stat_bit(input int idx, output logic b);
    host.xfer(1'b0, `STF_OFF_STAT, 8'h00);
    b = host.rd_data[idx];
  endtask
  task automatic wait_stat(input int idx, input logic val);
    logic b;
    int k;
    k = 0;
    do
    begin
      stat_bit(idx, b);
      k++;
    end
    while (b !== val && k < 500);
    check("status poll", 32'(b), 32'(val));
  endtask
  task automatic ticks(input int t);
    repeat (t) @(negedge txc);
  endtask
  // Expected line bits, lsb first, optional zero insertion
  task automatic add_bits(input logic [15:0] w, input int cnt, input bit stuff);
    for (int i = 0; i < cnt; i++)
    begin
      exp_q.push_back(w[i]);
      run1 = w[i] ? run1 + 1 : 0;
      if (stuff && run1 == 5)
      begin
        exp_q.push_back(1'b0);
        run1 = 0;
      end
    end
  endtask
  function automatic bit seen_on_line();
    bit hit;
    for (int i = 0; i + exp_q.size() <= line_q.size(); i++)
    begin
      hit = 1'b1;
      for (int j = 0; j < exp_q.size(); j++)
        hit &= (line_q[i + j] == exp_q[j]);
      if (hit)
        return 1'b1;
    end
    return 1'b0;
  endfunction
  function automatic logic [15:0] crc_of(input logic [15:0] d);
    logic [15:0] c;
    c = `STF_CRC_PRESET;
    for (int i = 0; i < 16; i++)
      c = (c >> 1) ^ ((c[0] ^ d[i]) ? `STF_CRC_POLY : 16'h0000);
    return c;
  endfunction
  initial
  begin
    #1_000_000;
    errors++;
    results();
  end
  // ---------------------------------------------
  // Tests
  // ---------------------------------------------
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    check("idle line", 32'({txd_q, int_n_q, dtr_n_q, rts_n_q}), 32'hf);
    stat_bit(1, v);
    check("closed after reset", 32'(v), 32'h1);
    foreach (rows[i])
    begin
      host.xfer(rows[i].wr, rows[i].addr, rows[i].data);
      repeat (2) @(posedge pclk);
      check("slverr", 32'(host.rd_err), 32'(rows[i].err));
      check("rdata", host.rd_data, 32'(rows[i].rdata));
      check("dtr rts", 32'({dtr_n_q, rts_n_q}), 32'({rows[i].dtr_n, rows[i].rts_n}));
    end
    host.xfer(1'b1, `STF_OFF_INTCTL, 8'h03);
    host.open_link(8'heb);
    ticks(24);
    add_bits(`STF_FLAG_WORD, 8, 1'b0);
    add_bits(`STF_FLAG_WORD, 8, 1'b0);
    check("flags", 32'(seen_on_line()), 32'h1);
    check("no early int", 32'(int_n_q), 32'h1);
    line_q.delete();
    ticks(10);
    host.first_char(8'h7e);
    stat_bit(1, v);
    check("closed cleared", 32'(v), 32'h0);
    wait_stat(0, 1'b1);
    check("tx int", 32'(int_n_q), 32'h0);
    host.xfer(1'b1, `STF_OFF_DATA, 8'hc3);
    wait_stat(4, 1'b1);
    check("crc stat", 32'({host.rd_data[3], host.rd_data[1:0]}), 32'h6);
    host.xfer(1'b1, `STF_OFF_CMD, 8'h05);
    wait_stat(4, 1'b0);
    check("after crc", 32'({host.rd_data[2], host.rd_data[0]}), 32'h3);
    ticks(12);
    exp_q.delete();
    run1 = 0;
    add_bits(`STF_FLAG_WORD, 8, 1'b0);
    add_bits(16'hc37e, 16, 1'b1);
    add_bits(~crc_of(16'hc37e), 16, 1'b1);
    add_bits(`STF_FLAG_WORD, 8, 1'b0);
    check("frame", 32'(seen_on_line()), 32'h1);
    host.xfer(1'b1, `STF_OFF_CMD, 8'h05);
    stat_bit(2, v);
    check("pending cleared", 32'(v), 32'h0);
    host.xfer(1'b1, `STF_OFF_CMD, 8'h02);
    host.first_char(8'h55);
    wait_stat(4, 1'b1);
    host.xfer(1'b1, `STF_OFF_CMD, 8'h01);
    line_q.delete();
    ticks(36);
    n = 0;
    best = 0;
    foreach (line_q[i])
    begin
      n = line_q[i] ? n + 1 : 0;
      best = (n > best) ? n : best;
    end
    check("abort ones", 32'(best >= 8 && best < 14), 32'h1);
    exp_q.delete();
    add_bits(`STF_FLAG_WORD, 8, 1'b0);
    add_bits(`STF_FLAG_WORD, 8, 1'b0);
    check("flags after abort", 32'(seen_on_line()), 32'h1);
    host.xfer(1'b1, `STF_OFF_INTCTL, 8'h0c);
    line_q.delete();
    ticks(10);
    check("ready low", 32'(ready_n_q), 32'h0);
    @(posedge txc);
    host.xfer(1'b1, `STF_OFF_DATA, 8'h0f);
    repeat (2) @(posedge pclk);
    check("ready high", 32'(ready_n_q), 32'h1);
    ticks(24);
    exp_q.delete();
    add_bits(`STF_FLAG_WORD, 8, 1'b0);
    add_bits(16'h000f, 8, 1'b0);
    add_bits(`STF_FLAG_WORD, 8, 1'b0);
    check("flags on underrun", 32'(seen_on_line()), 32'h1);
    host.xfer(1'b1, `STF_OFF_INTCTL, 8'h04);
    @(posedge txc);
    host.xfer(1'b1, `STF_OFF_DATA, 8'haa);
    repeat (2) @(posedge pclk);
    check("wait low", 32'(wait_n_q), 32'h0);
    wait (wait_n_q === 1'b1);
    host.xfer(1'b1, `STF_OFF_DATA, 8'hcc);
    host.xfer(1'b1, `STF_OFF_DATA, 8'hbb);
    check("write stretched", 32'(host.stall > 4), 32'h1);
    host.xfer(1'b1, `STF_OFF_TXCTL, 8'h00);
    ticks(30);
    check("marking", 32'({txd_q, dtr_n_q, rts_n_q}), 32'h7);
    results();
  end
endmodule
